// File: rtl/clgp_port.sv
`timescale 1ns/10ps
`default_nettype none
module clgp_port #(
   parameter int BIT_CYCLES = clgp_pkg::BIT_CYCLES_DEF
) (
   // System clock and reset
   input  wire logic                                   mclk,
   input  wire logic                                   rst,
   // Link side
   input  wire logic                                   linkClk,
   input  wire logic [clgp_pkg::LINK_BITS-1:0]         linkX,
   input  wire logic [clgp_pkg::LINK_BITS-1:0]         linkY,
   input  wire logic [clgp_pkg::LINK_BITS-1:0]         linkZ,
   // Configuration
   input  wire clgp_pkg::clgp_cfg_t                    cfgMode,
   // Pixel output
   output logic [clgp_pkg::PIX_BITS-1:0]               pixData,
   output logic                                        pixValid,
   output logic                                        frameValid,
   output logic                                        lineValid,
   output logic                                        frameStart,
   output logic                                        lineDone,
   output logic [clgp_pkg::LINE_CNT_W-1:0]             lineCount,
   output logic [clgp_pkg::LINE_CNT_W-1:0]             lineLength,
   output logic                                        enableSkew,
   // Camera control
   input  wire logic                                   exposureSyncPulse,
   input  wire logic                                   pixelResetSignal,
   input  wire logic                                   scanDirection,
   input  wire logic                                   ccUserSel,
   input  wire logic [clgp_pkg::CC_LINES-1:0]          ccUser,
   output logic [clgp_pkg::CC_LINES-1:0]               camCtrl,
   // Serial link
   input  wire logic                                   serTfg,
   output logic                                        serTc,
   input  wire logic [7:0]                             txData,
   input  wire logic                                   txValid,
   output logic                                        txReady,
   output logic [7:0]                                  rxData,
   output logic                                        rxValid,
   output logic                                        rxError
);
   import clgp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Link domain reset and configuration crossing
   logic                     rstLMeta_r;
   logic                     rstL_r;
   logic [1:0]               cfgLMeta_r;
   logic [1:0]               cfgL_r;

   // Link clock may stall between frames; reset lands on its next edges
   always_ff @(posedge linkClk) begin
      rstLMeta_r <= rst;
      rstL_r     <= rstLMeta_r;
   end

   // Configuration is quasi static, each bit synchronised on its own
   always_ff @(posedge linkClk) begin
      if (rstL_r) begin
         cfgLMeta_r <= CLGP_BASE;
         cfgL_r     <= CLGP_BASE;
      end else begin
         cfgLMeta_r <= cfgMode;
         cfgL_r     <= cfgLMeta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link word capture
   logic [LINK_BITS-1:0]     linkIn [LINKS];
   logic [PIX_BITS-1:0]      linkPix;
   logic                     wordHit;
   logic [PIX_BITS-1:0]      slot0_r;
   logic [PIX_BITS-1:0]      slot1_r;
   logic                     wrSel_r;
   logic                     wrTog_r;
   logic                     fvL_r;
   logic                     lvL_r;
   logic                     skewL_r;
   logic [2:0]               en0;
   logic [2:0]               en1;
   logic [2:0]               en2;

   assign linkIn[0] = linkX;
   assign linkIn[1] = linkY;
   assign linkIn[2] = linkZ;

   // Port p is byte p mod 3 of link p div 3; the top byte of the
   // third link is unused and left alone
   generate
      for (genvar p = 0; p < PORTS; p++) begin : g_port
         assign linkPix[p*PORT_BITS +: PORT_BITS] =
            linkIn[p / PORTS_LINK][(p % PORTS_LINK)*PORT_BITS +: PORT_BITS];
      end
   endgenerate

   // Enables are taken from the first link only; spare is never read
   assign wordHit = linkIn[0][FVAL_BIT] && linkIn[0][LVAL_BIT] && linkIn[0][DVAL_BIT];

   // Ping-pong slots: each holds two link periods, enough for the
   // system side to see the toggle and copy the word
   always_ff @(posedge linkClk) begin
      if (rstL_r) begin
         wrSel_r <= 1'b0;
         wrTog_r <= 1'b0;
      end else if (wordHit) begin
         wrSel_r <= ~wrSel_r;
         wrTog_r <= ~wrTog_r;
      end
   end

   always_ff @(posedge linkClk) begin
      if (wordHit && !wrSel_r) begin
         slot0_r <= linkPix;
      end
      if (wordHit && wrSel_r) begin
         slot1_r <= linkPix;
      end
   end

   always_ff @(posedge linkClk) begin
      if (rstL_r) begin
         fvL_r <= 1'b0;
         lvL_r <= 1'b0;
      end else begin
         fvL_r <= linkIn[0][FVAL_BIT];
         lvL_r <= linkIn[0][LVAL_BIT];
      end
   end

   // Links in use must carry the same enables as the first one
   assign en0 = linkIn[0][FVAL_BIT:DVAL_BIT];
   assign en1 = linkIn[1][FVAL_BIT:DVAL_BIT];
   assign en2 = linkIn[2][FVAL_BIT:DVAL_BIT];

   always_ff @(posedge linkClk) begin
      if (rstL_r) begin
         skewL_r <= 1'b0;
      end else begin
         skewL_r <= (cfgL_r != CLGP_BASE && en1 != en0) ||
                    (cfgL_r == CLGP_FULL && en2 != en0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System domain crossing
   logic                     togMeta_r;
   logic                     togSync_r;
   logic                     togSeen_r;
   logic                     rdSel_r;
   logic                     newWord;
   logic                     fvMeta_r;
   logic                     fvSync_r;
   logic                     lvMeta_r;
   logic                     lvSync_r;
   logic                     skMeta_r;
   logic                     skSync_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         togMeta_r <= 1'b0;
         togSync_r <= 1'b0;
         fvMeta_r  <= 1'b0;
         fvSync_r  <= 1'b0;
         lvMeta_r  <= 1'b0;
         lvSync_r  <= 1'b0;
         skMeta_r  <= 1'b0;
         skSync_r  <= 1'b0;
      end else begin
         togMeta_r <= wrTog_r;
         togSync_r <= togMeta_r;
         fvMeta_r  <= fvL_r;
         fvSync_r  <= fvMeta_r;
         lvMeta_r  <= lvL_r;
         lvSync_r  <= lvMeta_r;
         skMeta_r  <= skewL_r;
         skSync_r  <= skMeta_r;
      end
   end

   assign newWord = togSync_r ^ togSeen_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         togSeen_r <= 1'b0;
         rdSel_r   <= 1'b0;
      end else if (newWord) begin
         togSeen_r <= togSync_r;
         rdSel_r   <= ~rdSel_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pixel output
   logic [3:0]               portsOn;
   logic [PIX_BITS-1:0]      portMask;
   logic [PIX_BITS-1:0]      pixData_r;
   logic                     pixValid_r;

   always_comb begin
      unique case (cfgMode)
         CLGP_BASE:   portsOn = BASE_PORTS;
         CLGP_MEDIUM: portsOn = MEDIUM_PORTS;
         CLGP_FULL:   portsOn = FULL_PORTS;
         default:     portsOn = FULL_PORTS;
      endcase
   end

   // Ports beyond the configuration read as zero whatever the camera ties
   generate
      for (genvar p = 0; p < PORTS; p++) begin : g_mask
         assign portMask[p*PORT_BITS +: PORT_BITS] = {PORT_BITS{4'(p) < portsOn}};
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) begin
         pixData_r  <= '0;
         pixValid_r <= 1'b0;
      end else begin
         pixValid_r <= newWord;
         if (newWord) begin
            pixData_r <= (rdSel_r ? slot1_r : slot0_r) & portMask;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame and line tracking
   // Enables cross apart from the words and may lead them by a cycle
   logic                     fvPrev_r;
   logic                     lvPrev_r;
   logic                     frameStart_r;
   logic                     lineDone_r;
   logic [LINE_CNT_W-1:0]    lineCount_r;
   logic [LINE_CNT_W-1:0]    pixCount_r;
   logic [LINE_CNT_W-1:0]    lineLength_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         fvPrev_r     <= 1'b0;
         lvPrev_r     <= 1'b0;
         frameStart_r <= 1'b0;
         lineDone_r   <= 1'b0;
      end else begin
         fvPrev_r     <= fvSync_r;
         lvPrev_r     <= lvSync_r;
         frameStart_r <= fvSync_r && !fvPrev_r;
         lineDone_r   <= lvPrev_r && !lvSync_r && fvSync_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         lineCount_r <= '0;
      end else if (fvSync_r && !fvPrev_r) begin
         lineCount_r <= '0;
      end else if (lvPrev_r && !lvSync_r && fvSync_r) begin
         lineCount_r <= lineCount_r + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pixCount_r   <= '0;
         lineLength_r <= '0;
      end else if (lvPrev_r && !lvSync_r) begin
         lineLength_r <= pixCount_r + LINE_CNT_W'(pixValid_r);
         pixCount_r   <= '0;
      end else if (pixValid_r) begin
         pixCount_r <= pixCount_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Camera control outputs
   logic [CC_LINES-1:0]      camCtrl_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         camCtrl_r <= CC_RESET;
      end else if (ccUserSel) begin
         camCtrl_r <= ccUser;
      end else begin
         camCtrl_r <= {CC4_LEVEL, scanDirection, pixelResetSignal, exposureSyncPulse};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial link
   clgp_ser_if               ser ();
   logic                     rxMeta_r;
   logic                     rxSync_r;
   logic                     txReady_r;
   logic                     txTake;
   logic [7:0]               rxData_r;
   logic                     rxValid_r;
   logic                     rxError_r;

   // Idle level is high so reset does not fake a start bit
   always_ff @(posedge mclk) begin
      if (rst) begin
         rxMeta_r <= 1'b1;
         rxSync_r <= 1'b1;
      end else begin
         rxMeta_r <= serTfg;
         rxSync_r <= rxMeta_r;
      end
   end

   assign ser.rxLine = rxSync_r;
   assign txTake     = txValid && txReady_r;
   assign ser.txGo   = txTake;
   assign ser.txByte = txData;

   // No flow control on the wire; only the local ready paces the user
   always_ff @(posedge mclk) begin
      if (rst) begin
         txReady_r <= 1'b0;
      end else begin
         txReady_r <= !ser.txBusy && !txTake;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rxData_r  <= '0;
         rxValid_r <= 1'b0;
         rxError_r <= 1'b0;
      end else begin
         rxValid_r <= ser.rxStrobe;
         rxError_r <= ser.rxFault;
         if (ser.rxStrobe) begin
            rxData_r <= ser.rxByte;
         end
      end
   end

   clgp_ser_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
      .mclk (mclk),
      .rst  (rst),
      .ser  (ser.tx)
   );

   clgp_ser_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
      .mclk (mclk),
      .rst  (rst),
      .ser  (ser.rx)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign pixData    = pixData_r;
   assign pixValid   = pixValid_r;
   assign frameValid = fvSync_r;
   assign lineValid  = lvSync_r;
   assign frameStart = frameStart_r;
   assign lineDone   = lineDone_r;
   assign lineCount  = lineCount_r;
   assign lineLength = lineLength_r;
   assign enableSkew = skSync_r;
   assign camCtrl    = camCtrl_r;
   assign serTc      = ser.txLine;
   assign txReady    = txReady_r;
   assign rxData     = rxData_r;
   assign rxValid    = rxValid_r;
   assign rxError    = rxError_r;

endmodule
`default_nettype wire

// File: rtl/clgp_ser_rx.sv
`timescale 1ns/10ps
`default_nettype none
module clgp_ser_rx #(
   parameter int BIT_CYCLES = clgp_pkg::BIT_CYCLES_DEF
) (
   // System
   input  wire logic mclk,
   input  wire logic rst,
   // Character port, line already synchronised
   clgp_ser_if.rx    ser
);
   import clgp_pkg::*;

   localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYCLES - 1);
   localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CYCLES / 2 - 1);

   clgp_ser_t         state_r;
   logic [CNT_W-1:0]  cnt_r;
   logic [2:0]        bitIdx_r;
   logic [7:0]        shift_r;
   logic [7:0]        byte_r;
   logic              strobe_r;
   logic              fault_r;

   assign ser.rxByte   = byte_r;
   assign ser.rxStrobe = strobe_r;
   assign ser.rxFault  = fault_r;

   ////////////////////////////////////////////////////////////////////////
   // Samples at mid bit; a start bit that is gone at mid bit is a glitch
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r  <= CLGP_SER_IDLE;
         cnt_r    <= '0;
         bitIdx_r <= '0;
         shift_r  <= '0;
         byte_r   <= '0;
         strobe_r <= 1'b0;
         fault_r  <= 1'b0;
      end else begin
         strobe_r <= 1'b0;
         fault_r  <= 1'b0;
         cnt_r    <= cnt_r - 1'b1;
         unique case (state_r)
            CLGP_SER_IDLE: begin
               cnt_r <= HALF_LAST;
               if (!ser.rxLine) begin
                  state_r <= CLGP_SER_START;
               end
            end
            CLGP_SER_START: begin
               if (cnt_r == '0) begin
                  cnt_r    <= BIT_LAST;
                  bitIdx_r <= '0;
                  state_r  <= ser.rxLine ? CLGP_SER_IDLE : CLGP_SER_DATA;
               end
            end
            CLGP_SER_DATA: begin
               if (cnt_r == '0) begin
                  cnt_r   <= BIT_LAST;
                  shift_r <= {ser.rxLine, shift_r[7:1]};
                  if (bitIdx_r == LAST_BIT) begin
                     state_r <= CLGP_SER_STOP;
                  end else begin
                     bitIdx_r <= bitIdx_r + 1'b1;
                  end
               end
            end
            CLGP_SER_STOP: begin
               if (cnt_r == '0) begin
                  // No parity bit: the stop level is the only check
                  byte_r   <= shift_r;
                  strobe_r <= ser.rxLine;
                  fault_r  <= !ser.rxLine;
                  state_r  <= CLGP_SER_IDLE;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// File: rtl/clgp_ser_tx.sv
`timescale 1ns/10ps
`default_nettype none
module clgp_ser_tx #(
   parameter int BIT_CYCLES = clgp_pkg::BIT_CYCLES_DEF
) (
   // System
   input  wire logic mclk,
   input  wire logic rst,
   // Character port
   clgp_ser_if.tx    ser
);
   import clgp_pkg::*;

   localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);

   clgp_ser_t         state_r;
   logic [CNT_W-1:0]  cnt_r;
   logic [2:0]        bitIdx_r;
   logic [7:0]        shift_r;
   logic              line_r;
   logic              busy_r;

   assign ser.txLine = line_r;
   assign ser.txBusy = busy_r;

   ////////////////////////////////////////////////////////////////////////
   // One start bit, eight data bits LSB first, one stop bit, no parity
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r  <= CLGP_SER_IDLE;
         cnt_r    <= '0;
         bitIdx_r <= '0;
         shift_r  <= '0;
         line_r   <= 1'b1;
         busy_r   <= 1'b0;
      end else begin
         cnt_r <= cnt_r - 1'b1;
         unique case (state_r)
            CLGP_SER_IDLE: begin
               line_r <= 1'b1;
               cnt_r  <= BIT_LAST;
               if (ser.txGo) begin
                  shift_r <= ser.txByte;
                  busy_r  <= 1'b1;
                  line_r  <= 1'b0;
                  state_r <= CLGP_SER_START;
               end
            end
            CLGP_SER_START: begin
               if (cnt_r == '0) begin
                  line_r   <= shift_r[0];
                  shift_r  <= {1'b0, shift_r[7:1]};
                  bitIdx_r <= '0;
                  cnt_r    <= BIT_LAST;
                  state_r  <= CLGP_SER_DATA;
               end
            end
            CLGP_SER_DATA: begin
               if (cnt_r == '0) begin
                  cnt_r <= BIT_LAST;
                  if (bitIdx_r == LAST_BIT) begin
                     line_r  <= 1'b1;
                     state_r <= CLGP_SER_STOP;
                  end else begin
                     line_r   <= shift_r[0];
                     shift_r  <= {1'b0, shift_r[7:1]};
                     bitIdx_r <= bitIdx_r + 1'b1;
                  end
               end
            end
            CLGP_SER_STOP: begin
               if (cnt_r == '0) begin
                  busy_r  <= 1'b0;
                  state_r <= CLGP_SER_IDLE;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// File: shared/clgp_pkg.sv
package clgp_pkg;

   // Link word layout
   localparam int LINKS      = 3;
   localparam int LINK_BITS  = 28;
   localparam int DATA_BITS  = 24;
   localparam int FVAL_BIT   = 27;
   localparam int LVAL_BIT   = 26;
   localparam int DVAL_BIT   = 25;
   localparam int SPARE_BIT  = 24;

   // Byte ports A to H
   localparam int PORT_BITS  = 8;
   localparam int PORTS      = 8;
   localparam int PORTS_LINK = 3;
   localparam int PIX_BITS   = PORTS * PORT_BITS;

   localparam logic [3:0] BASE_PORTS   = 4'h3;
   localparam logic [3:0] MEDIUM_PORTS = 4'h6;
   localparam logic [3:0] FULL_PORTS   = 4'h8;

   typedef enum logic [1:0] {
      CLGP_BASE   = 2'b00,
      CLGP_MEDIUM = 2'b01,
      CLGP_FULL   = 2'b10
   } clgp_cfg_t;

   // Camera control lines, CC4 high at reset and whenever ccUserSel is low
   localparam int         CC_LINES = 4;
   localparam logic [3:0] CC_RESET = 4'h8;
   localparam logic       CC4_LEVEL = 1'b1;

   // Serial timing
   localparam longint CLK_HZ       = 40000000;
   localparam longint BAUD_RATE    = 9600;
   localparam int     BIT_CYCLES_DEF = int'(CLK_HZ / BAUD_RATE);
   localparam int     CNT_W        = 16;
   localparam int     CHAR_BITS    = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // Line statistics
   localparam int     LINE_CNT_W   = 16;

   typedef enum logic [1:0] {
      CLGP_SER_IDLE  = 2'b00,
      CLGP_SER_START = 2'b01,
      CLGP_SER_DATA  = 2'b10,
      CLGP_SER_STOP  = 2'b11
   } clgp_ser_t;

endpackage

// File: shared/clgp_ser_if.sv
`timescale 1ns/10ps
`default_nettype none
interface clgp_ser_if;
   logic [7:0] txByte;
   logic       txGo;
   logic       txBusy;
   logic       txLine;
   logic       rxLine;
   logic [7:0] rxByte;
   logic       rxStrobe;
   logic       rxFault;

   modport tx   (input txByte, input txGo, output txBusy, output txLine);
   modport rx   (input rxLine, output rxByte, output rxStrobe, output rxFault);
   modport port (output txByte, output txGo, input txBusy, input txLine,
                 output rxLine, input rxByte, input rxStrobe, input rxFault);
endinterface
`default_nettype wire

// File: tb/clgp_cam_model.sv
`timescale 1ns/10ps
`default_nettype none
module clgp_cam_model #(
   parameter int BIT_CYCLES = 16
) (
   // Link clock and 28 bit words
   output logic        linkClk,
   output logic [27:0] linkX,
   output logic [27:0] linkY,
   output logic [27:0] linkZ,
   // Serial toward the grabber
   output logic        serTfg
);
   localparam real BIT_NS = BIT_CYCLES * 25.0;
   // Pixel clock runs free, phase unrelated to mclk
   initial begin
      linkClk = 1'b0;
      #7;
      forever #40 linkClk = ~linkClk;
   end
   initial begin
      linkX = '0;
      linkY = '0;
      linkZ = '0;
      serTfg = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // Words are driven as given for one link cycle, then every link returns to zero
   task automatic sendWord(input logic [27:0] x, input logic [27:0] y, input logic [27:0] z);
      @(posedge linkClk);
      #2;
      linkX = x;
      linkY = y;
      linkZ = z;
      @(posedge linkClk);
      #2;
      linkX = '0;
      linkY = '0;
      linkZ = '0;
   endtask
   task automatic sendChar(input logic [7:0] b, input logic badStop);
      serTfg = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++) begin
         serTfg = b[i];
         #(BIT_NS);
      end
      serTfg = !badStop;
      #(BIT_NS);
      serTfg = 1'b1;
      #(2 * BIT_NS);
   endtask
endmodule
`default_nettype wire

// File: tb/clgp_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module clgp_port_assertions #(
   parameter int BIT_CYCLES = 16
) (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rst,
   // Camera control
   input wire logic       exposureSyncPulse,
   input wire logic       pixelResetSignal,
   input wire logic       scanDirection,
   input wire logic       ccUserSel,
   input wire logic [3:0] ccUser,
   input wire logic [3:0] camCtrl,
   // Pixel and serial
   input wire logic       pixValid,
   input wire logic       txValid,
   input wire logic       txReady,
   input wire logic       serTc,
   input wire logic       rxValid,
   input wire logic       rxError
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   a_cc4_high: assert property (!ccUserSel |=> camCtrl[3])
      else $error("fourth control line not high");
   a_cc_defaults: assert property (!ccUserSel |=> camCtrl[2:0] ==
      {$past(scanDirection), $past(pixelResetSignal), $past(exposureSyncPulse)})
      else $error("default control mapping wrong");
   a_cc_user: assert property (ccUserSel |=> camCtrl == $past(ccUser))
      else $error("user control value not driven");
   a_pix_once: assert property (pixValid |=> !pixValid)
      else $error("pixel strobe longer than one cycle");
   a_tx_idle: assert property (txReady |-> serTc)
      else $error("serial out not idle high");
   a_tx_start: assert property (txValid && txReady |=> !serTc && !txReady)
      else $error("start bit not sent after take");
   a_start_len: assert property ($fell(serTc) |-> !serTc [*8])
      else $error("start bit too short");
   a_rx_excl: assert property (!(rxValid && rxError))
      else $error("good and bad character at once");
endmodule
bind clgp_port clgp_port_assertions #(.BIT_CYCLES(BIT_CYCLES)) clgp_port_assertions_i (
   .mclk, .rst, .exposureSyncPulse, .pixelResetSignal, .scanDirection, .ccUserSel,
   .ccUser, .camCtrl, .pixValid, .txValid, .txReady, .serTc, .rxValid, .rxError);
`default_nettype wire

// File: tb/clgp_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module clgp_port_tb_top;
   import clgp_pkg::*;
   localparam int BC = 16;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   int          failCount = 0;
   int          compares = 0;
   int          seed = 32'h4ba2;
   clgp_cfg_t   cfgMode = CLGP_BASE;
   logic        exposureSyncPulse = 1'b0;
   logic        pixelResetSignal = 1'b0;
   logic        scanDirection = 1'b0;
   logic        ccUserSel = 1'b0;
   logic [3:0]  ccUser = 4'h0;
   logic [7:0]  txData = 8'h00;
   logic        txValid = 1'b0;
   logic        linkClk;
   logic [27:0] linkX;
   logic [27:0] linkY;
   logic [27:0] linkZ;
   logic        serTfg;
   logic [63:0] pixData;
   logic        pixValid;
   logic [3:0]  camCtrl;
   logic        serTc;
   logic        txReady;
   logic [7:0]  rxData;
   logic        rxValid;
   logic        rxError;
   logic        enableSkew;
   always #12.5 mclk = ~mclk;
   clgp_cam_model #(.BIT_CYCLES(BC)) clgp_cam_model_i (.linkClk, .linkX, .linkY, .linkZ, .serTfg);
   clgp_port #(.BIT_CYCLES(BC)) clgp_port_i (.mclk, .rst, .linkClk, .linkX, .linkY, .linkZ,
      .cfgMode, .pixData, .pixValid, .frameValid(), .lineValid(), .frameStart(), .lineDone(),
      .lineCount(), .lineLength(), .enableSkew, .exposureSyncPulse, .pixelResetSignal,
      .scanDirection, .ccUserSel, .ccUser, .camCtrl, .serTfg, .serTc, .txData, .txValid,
      .txReady, .rxData, .rxValid, .rxError);
   ////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic endOfTest;
      $display("compares %0d failCount %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Bounded wait; a missed must-have event ends the run
   task automatic waitOn(input int sel, input int lim, input bit must, output bit hit);
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge mclk);
         #1;
         hit = (sel == 0) ? pixValid === 1'b1 : (sel == 1) ? (rxValid === 1'b1 || rxError === 1'b1)
               : (sel == 2) ? txReady === 1'b1 : enableSkew === 1'b1;
      end
      if (must && !hit) begin
         failCount++;
         $display("wrong value wait %0d expected 1 seen 0", sel);
         endOfTest();
      end
   endtask
   function automatic logic [63:0] expPix(input int c, input logic [27:0] x, y, z);
      expPix = {40'h0, x[23:0]};
      if (c > 0) expPix[47:24] = y[23:0];
      if (c > 1) expPix[63:48] = z[15:0];
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      logic [27:0] x, y, z;
      logic [63:0] pix;
      logic [7:0]  b, good;
      bit          hit, sk;
      int          r;
      repeat (10) @(posedge mclk);
      #2 rst = 1'b0;
      @(posedge mclk);
      #2;
      chk("camCtrl", CC_RESET, camCtrl);
      chk("serTc", 1, serTc);
      for (int i = 0; i < 12; i++) begin
         r = $random(seed);
         {ccUser, ccUserSel, scanDirection, pixelResetSignal, exposureSyncPulse} = r[7:0];
         @(posedge mclk);
         #2;
         chk("camCtrl", ccUserSel ? ccUser : {1'b1, scanDirection, pixelResetSignal, exposureSyncPulse}, camCtrl);
      end
      ccUserSel = 1'b0;
      $display("test camera control done");
      for (int c = 0; c < 3; c++) begin
         cfgMode = clgp_cfg_t'(c);
         repeat (4) @(posedge mclk);
         for (int k = 0; k < 5; k++) begin
            // Spare bit 24 random so it must be ignored; unused links tied
            // to a fixed nonzero value so the port mask is exercised
            x = {3'b111, 25'($random(seed))};
            y = {x[27:24], (c > 0) ? 24'($random(seed)) : 24'h5a5a5a};
            z = {x[27:24], (c > 1) ? 24'($random(seed)) : 24'h5a5a5a};
            if (k == 4) x[25 + $unsigned($random(seed)) % 3] = 1'b0;
            fork
               clgp_cam_model_i.sendWord(x, y, z);
               waitOn(0, 20, k < 4, hit);
               if (k == 4) begin
                  waitOn(3, 20, 1'b0, sk);
                  chk("enableSkew", c > 0, sk);
               end
            join
            chk("pixData", (k < 4) ? expPix(c, x, y, z) : pix, pixData);
            chk("pixValid", k < 4, hit);
            if (k < 4) pix = expPix(c, x, y, z);
         end
      end
      $display("test pixel capture done");
      for (int i = 0; i < 3; i++) begin
         b = (i == 0) ? 8'h01 : 8'($random(seed));
         waitOn(2, 400, 1'b1, hit);
         #1 txData = b;
         txValid = 1'b1;
         @(posedge mclk);
         #2 txValid = 1'b0;
         repeat (1 + BC + BC / 2) @(posedge mclk);
         for (int j = 0; j < 9; j++) begin
            #1 chk("serTc", (j < 8) ? b[j] : 1'b1, serTc);
            repeat (BC) @(posedge mclk);
         end
      end
      $display("test serial transmit done");
      good = 8'h00;
      for (int i = 0; i < 4; i++) begin
         b = 8'($random(seed));
         if (i < 3) good = b;
         fork
            clgp_cam_model_i.sendChar(b, i == 3);
            begin
               waitOn(1, 20 * BC, 1'b1, hit);
               chk("rxValid", i < 3, rxValid);
               chk("rxData", good, rxData);
               chk("rxError", i == 3, rxError);
            end
         join
      end
      $display("test serial receive done");
      endOfTest();
   end
endmodule
`default_nettype wire
